// *** hw/tcd_map.vh ***
`ifndef TCD_MAP_VH
`define TCD_MAP_VH

// ****************************************
// register addresses
// ****************************************
`define TCD_ADDR_W          6
`define TCD_ADDR_DESC       6'h08
`define TCD_ADDR_READOUT    6'h09
`define TCD_DATA_W          16

// ****************************************
// descriptor field positions and values
// ****************************************
`define TCD_RES_LSB         0
`define TCD_RES_W           3
`define TCD_RES_HALF_DEG    3'h1
`define TCD_NBITS_LSB       3
`define TCD_NBITS_W         3
`define TCD_NBITS_TEN       3'h1
`define TCD_SIGN_BIT        6
`define TCD_SIGN_TWOS       1'h1
`define TCD_RSIZE_BIT       7
`define TCD_RSIZE_16        1'h0
`define TCD_ONCHIP_BIT      8
`define TCD_ONCHIP_YES      1'h1
`define TCD_REMOTES_LSB     9
`define TCD_REMOTES_W       3
`define TCD_REMOTES_TWO     3'h2
`define TCD_RSVD_LSB        12
`define TCD_RSVD_W          4
`define TCD_RSVD_VAL        4'h0
`define TCD_DESC_VALUE      16'h0549

// ****************************************
// readout register layout
// ****************************************
`define TCD_TEMP_W          10
`define TCD_TEMP_LSB        6
`define TCD_SRC_LSB         2
`define TCD_SRC_W           2
`define TCD_FAULT_BIT       1
`define TCD_SRC_LOCAL       2'h0
`define TCD_ZERO16          16'h0000
`define TCD_ZERO10          10'h000
`define TCD_ZERO2           2'h0

`endif

// *** hw/tcd_desc_word.v ***
`include "tcd_map.vh"
`default_nettype none

// ****************************************
// fixed format descriptor
// ****************************************
// pure wiring of constants: no state, so no reset can disturb it
module tcd_desc_word (
    output wire [`TCD_DATA_W-1:0] descWord
);
    wire [`TCD_RES_W-1:0]     resolutionCode;
    wire [`TCD_NBITS_W-1:0]   bitCountCode;
    wire                      signedFlag;
    wire                      result_width_flag;
    wire                      internal_sensor_flag;
    wire [`TCD_REMOTES_W-1:0] remote_input_count;
    wire [`TCD_RSVD_W-1:0]    reservedBits;

    assign resolutionCode       = `TCD_RES_HALF_DEG;
    assign bitCountCode         = `TCD_NBITS_TEN;
    assign signedFlag           = `TCD_SIGN_TWOS;
    assign result_width_flag    = `TCD_RSIZE_16;
    assign internal_sensor_flag = `TCD_ONCHIP_YES;
    assign remote_input_count   = `TCD_REMOTES_TWO;
    assign reservedBits         = `TCD_RSVD_VAL;

    // field order follows the bit map from msb down; totals 0549h
    assign descWord = {reservedBits, remote_input_count, internal_sensor_flag,
                       result_width_flag, signedFlag, bitCountCode,
                       resolutionCode};
endmodule // tcd_desc_word

`default_nettype wire

// *** hw/tcd_top.v ***
`include "tcd_map.vh"
`default_nettype none

// How it works
// - resolution field reads 001, half degree
// - bit count field reads 001, ten bits
// - sign bit reads one, two's complement
// - readout size bit reads zero, sixteen bits
// - internal sensor bit reads one
// - remote count field reads two
// - top four bits always read zero
// - address 08h read-only, constant 0549h
// - one result format for every sensor
// - ten-bit result left justified, bits 15-6
module tcd_top (
    input  wire                    sys_clk,
    input  wire                    rst_n,
    input  wire [`TCD_ADDR_W-1:0]  regAddr,
    input  wire                    regRdStb,
    input  wire                    regWrStb,
    input  wire [`TCD_DATA_W-1:0]  regWrData,
    output reg  [`TCD_DATA_W-1:0]  regRdData_ff,
    output reg                     regRdValid_ff,
    input  wire [`TCD_TEMP_W-1:0]  tempCode,
    input  wire [`TCD_SRC_W-1:0]   tempSensor,
    input  wire                    tempErr,
    input  wire                    tempStb,
    output reg                     resultPending_ff,
    output reg                     resultOverrun_ff
);

    // ****************************************
    // descriptor constant
    // ****************************************
    // built from constants in its own module, so no reset, write or
    // result can ever reach it
    wire [`TCD_DATA_W-1:0] descWord;

    tcd_desc_word u_desc (
        .descWord (descWord)
    );

    // ****************************************
    // result fields
    // ****************************************
    wire [`TCD_TEMP_W-1:0] tempField;
    wire [`TCD_SRC_W-1:0]  srcField;
    wire                   srcIsLocal;
    wire                   faultField;

    // sensor numbers above two are passed on as given, not filtered
    assign tempField  = tempCode;
    assign srcField   = tempSensor;
    assign srcIsLocal = (tempSensor == `TCD_SRC_LOCAL);

    // the local slot has no diode, so a fault there is meaningless and
    // the bit is held low for it
    assign faultField = tempErr && !srcIsLocal;

    // ****************************************
    // readout layout
    // ****************************************
    // one shared layout for local and remote results alike
    // the code carries its own sign at the top, so no extension is needed
    // bits 5-4 and bit 0 have no meaning and always read zero
    wire [`TCD_DATA_W-1:0] placedResult;

    genvar gi;
    generate
        for (gi = 0; gi < `TCD_DATA_W; gi = gi + 1) begin : g_place
            if (gi >= `TCD_TEMP_LSB) begin : g_temp
                assign placedResult[gi] = tempField[gi-`TCD_TEMP_LSB];
            end else if (gi >= `TCD_SRC_LSB && gi < `TCD_SRC_LSB + `TCD_SRC_W) begin : g_src
                assign placedResult[gi] = srcField[gi-`TCD_SRC_LSB];
            end else if (gi == `TCD_FAULT_BIT) begin : g_fault
                assign placedResult[gi] = faultField;
            end else begin : g_zero
                assign placedResult[gi] = 1'h0;
            end
        end
    endgenerate

    // ****************************************
    // readout register
    // ****************************************
    // holds the newest result only; an unread one is overwritten and
    // the overrun flag records the loss
    // reset clears it; only the descriptor is untouched by reset
    reg [`TCD_DATA_W-1:0] readout_ff;
    reg [`TCD_DATA_W-1:0] nxt_readout;

    always @* begin
        nxt_readout = readout_ff;
        if (tempStb) begin
            nxt_readout = placedResult;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            readout_ff <= `TCD_ZERO16;
        end else begin
            readout_ff <= nxt_readout;
        end
    end

    // ****************************************
    // read address decode
    // ****************************************
    // only a read of the readout register has a side effect: it retires
    // the flags. reading the descriptor disturbs nothing
    wire rdReadout;

    assign rdReadout = regRdStb && (regAddr == `TCD_ADDR_READOUT);

    // ****************************************
    // read data select
    // ****************************************
    // unmapped addresses answer zero rather than an alias, so a host
    // probing the map cannot mistake a hole for a register
    reg [`TCD_DATA_W-1:0] nxt_rdData;

    always @* begin
        nxt_rdData = `TCD_ZERO16;
        if (regRdStb) begin
            case (regAddr)
                `TCD_ADDR_DESC: begin
                    nxt_rdData = descWord;
                end
                `TCD_ADDR_READOUT: begin
                    nxt_rdData = readout_ff;
                end
                default: begin
                    nxt_rdData = `TCD_ZERO16;
                end
            endcase
        end
    end

    // ****************************************
    // read answer
    // ****************************************
    // data reads zero outside its answer cycle, so a stray sample by the
    // host shows nothing stale; valid follows every read, mapped or not
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            regRdData_ff  <= `TCD_ZERO16;
            regRdValid_ff <= 1'h0;
        end else begin
            regRdData_ff  <= nxt_rdData;
            regRdValid_ff <= regRdStb;
        end
    end

    // ****************************************
    // write path
    // ****************************************
    // neither register here is writable; a write to 08h or 09h changes
    // nothing. regWrData is deliberately left unread by this block.
    wire wrHitsDesc;

    assign wrHitsDesc = regWrStb && (regAddr == `TCD_ADDR_DESC);

    // ****************************************
    // pending flag
    // ****************************************
    // a new result landing on the same edge as the read that clears
    // the flag wins, so no result goes unannounced
    reg nxt_pending;

    always @* begin
        nxt_pending = resultPending_ff;
        if (rdReadout) begin
            nxt_pending = 1'h0;
        end
        if (tempStb) begin
            nxt_pending = 1'h1;
        end
    end

    // ****************************************
    // overrun flag
    // ****************************************
    // only a result that replaces an unread one counts as lost; a read
    // in the same cycle takes the old result out first
    reg nxt_overrun;

    always @* begin
        nxt_overrun = resultOverrun_ff;
        if (rdReadout) begin
            nxt_overrun = 1'h0;
        end
        if (tempStb && resultPending_ff && !rdReadout) begin
            nxt_overrun = 1'h1;
        end
    end

    // ****************************************
    // status flops
    // ****************************************
    // the flags clear only on a read of the readout register or on reset
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            resultPending_ff <= 1'h0;
        end else begin
            resultPending_ff <= nxt_pending;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            resultOverrun_ff <= 1'h0;
        end else begin
            resultOverrun_ff <= nxt_overrun;
        end
    end

endmodule // tcd_top

`default_nettype wire

// *** tb/tcd_top_asserts.sv ***
`include "tcd_map.vh"
`default_nettype none
module tcd_top_asserts (
    input wire logic                   sys_clk,
    input wire logic                   rst_n,
    input wire logic [`TCD_ADDR_W-1:0] regAddr,
    input wire logic                   regRdStb,
    input wire logic                   regWrStb,
    input wire logic [`TCD_DATA_W-1:0] regRdData_ff,
    input wire logic                   regRdValid_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    logic descRd_ff;
    logic outRd_ff;
    always_ff @(posedge sys_clk) begin
        descRd_ff <= rst_n && regRdStb && regAddr == `TCD_ADDR_DESC;
        outRd_ff  <= rst_n && regRdStb && regAddr == `TCD_ADDR_READOUT;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_res_field: assert property (descRd_ff |-> regRdData_ff[2:0] == 3'h1)
        else $error("resolution field wrong");
    a_nbits_field: assert property (descRd_ff |-> regRdData_ff[5:3] == 3'h1)
        else $error("bit count field wrong");
    a_sign_bit: assert property (descRd_ff |-> regRdData_ff[6])
        else $error("sign bit wrong");
    a_rsize_bit: assert property (descRd_ff |-> !regRdData_ff[7])
        else $error("result width flag wrong");
    a_onchip_sensor: assert property (descRd_ff |-> regRdData_ff[8])
        else $error("internal sensor flag wrong");
    a_remote_field: assert property (descRd_ff |-> regRdData_ff[11:9] == 3'h2)
        else $error("remote input count wrong");
    a_rsvd_zero: assert property (descRd_ff |-> regRdData_ff[15:12] == 4'h0)
        else $error("unused bits not zero");
    a_rd_answer: assert property (regRdStb |=> regRdValid_ff)
        else $error("read not answered");
    a_readout_gap: assert property (outRd_ff |-> regRdData_ff[5:4] == 2'h0 && !regRdData_ff[0])
        else $error("readout fixed bits wrong");
    a_wr_silent: assert property (regWrStb && !regRdStb |=> !regRdValid_ff)
        else $error("write gave an answer");
    a_idle_zero: assert property (!regRdValid_ff |-> regRdData_ff == 16'h0000)
        else $error("read data not zero when idle");
endmodule // tcd_top_asserts
`default_nettype wire

// *** tb/tcd_host.sv ***
`include "tcd_map.vh"
`default_nettype none
module tcd_host (
    input  wire logic                   sys_clk,
    output var  logic [`TCD_ADDR_W-1:0] regAddr,
    output var  logic                   regRdStb,
    output var  logic                   regWrStb,
    output var  logic [`TCD_DATA_W-1:0] regWrData,
    input  wire logic [`TCD_DATA_W-1:0] regRdData_ff,
    input  wire logic                   regRdValid_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        regAddr = 6'h3f;
        regRdStb = 1'b0;
        regWrStb = 1'b0;
        regWrData = 16'hffff;
    end
    // idle lines show the inverse so stale values cannot pass
    task automatic access(input logic wr, input logic [5:0] a, input logic [15:0] d,
                          output logic [15:0] q, output logic v);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regRdStb <= !wr;
        regWrStb <= wr;
        @(posedge sys_clk);
        regAddr <= ~a;
        regWrData <= ~d;
        regRdStb <= 1'b0;
        regWrStb <= 1'b0;
        #1;
        q = regRdData_ff;
        v = regRdValid_ff;
    endtask
endmodule // tcd_host
`default_nettype wire

// *** tb/tcd_top_test.sv ***
`include "tcd_map.vh"
`default_nettype none
module tcd_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [5:0]  regAddr;
    logic [15:0] regWrData, regRdData_ff, q;
    logic        regRdStb, regWrStb, regRdValid_ff, pend, ovr, v;
    logic [9:0]  tempCode = 10'h000;
    logic [1:0]  tempSensor = 2'h0;
    logic        tempErr = 1'b0;
    logic        tempStb = 1'b0;
    int          n_mismatch = 0;
    int          total_checks = 0;
    logic [21:0] rows [4] = '{{6'h08, 16'h0549}, {6'h00, 16'h0000}, {6'h09, 16'h0000},
                              {6'h3f, 16'h0000}};
    always #10 sys_clk = ~sys_clk;
    tcd_top tcd_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regRdStb(regRdStb), .regWrStb(regWrStb), .regWrData(regWrData),
        .regRdData_ff(regRdData_ff), .regRdValid_ff(regRdValid_ff), .tempCode(tempCode),
        .tempSensor(tempSensor), .tempErr(tempErr), .tempStb(tempStb),
        .resultPending_ff(pend), .resultOverrun_ff(ovr));
    tcd_host tcd_host_i (.sys_clk(sys_clk), .regAddr(regAddr), .regRdStb(regRdStb),
        .regWrStb(regWrStb), .regWrData(regWrData), .regRdData_ff(regRdData_ff),
        .regRdValid_ff(regRdValid_ff));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
        chk("reset read data", 16'h0000, regRdData_ff);
        chk("reset flags", 16'h0000, {13'h0, regRdValid_ff, pend, ovr});
        foreach (rows[i]) begin
            tcd_host_i.access(1'b0, rows[i][21:16], 16'h0000, q, v);
            chk("read data", rows[i][15:0], q);
            chk("read valid", 16'h0001, {15'h0000, v});
        end
        tcd_host_i.access(1'b1, 6'h08, 16'hffff, q, v);
        chk("write answer", 16'h0000, {15'h0000, v});
        tcd_host_i.access(1'b0, 6'h08, 16'h0000, q, v);
        chk("desc after write", 16'h0549, q);
        @(posedge sys_clk);
        {tempCode, tempSensor, tempErr, tempStb} <= {10'h0c8, 2'h0, 1'b1, 1'b1};
        @(posedge sys_clk);
        {tempCode, tempSensor} <= {10'h3b0, 2'h2};
        @(posedge sys_clk);
        tempStb <= 1'b0;
        #1;
        chk("flags set", 16'h0003, {14'h0000, pend, ovr});
        tcd_host_i.access(1'b0, 6'h09, 16'h0000, q, v);
        chk("remote readout", 16'hec0a, q);
        chk("flags clear", 16'h0000, {14'h0000, pend, ovr});
        @(posedge sys_clk);
        {tempCode, tempSensor, tempStb} <= {10'h0c8, 2'h0, 1'b1};
        @(posedge sys_clk);
        tempStb <= 1'b0;
        tcd_host_i.access(1'b0, 6'h09, 16'h0000, q, v);
        chk("local readout", 16'h3200, q);
        @(posedge sys_clk);
        {tempCode, tempSensor, tempErr, tempStb} <= {10'h3ff, 2'h1, 1'h0, 1'h1};
        fork
            tcd_host_i.access(1'h0, 6'h09, 16'h0000, q, v);
            begin
                @(posedge sys_clk);
                {tempCode, tempSensor} <= {10'h201, 2'h2};
                @(posedge sys_clk);
                tempStb <= 1'h0;
            end
        join
        chk("negative readout", 16'hffc4, q);
        chk("set wins", 16'h0002, {14'h0000, pend, ovr});
        tcd_host_i.access(1'h0, 6'h09, 16'h0000, q, v);
        chk("lowest readout", 16'h8048, q);
        @(posedge sys_clk);
        tempStb <= 1'h1;
        @(posedge sys_clk);
        tempStb <= 1'h0;
        rst_n <= 1'h0;
        #1;
        chk("pending before reset", 16'h0001, {15'h0, pend});
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'h1;
        #1;
        chk("flags after reset", 16'h0000, {13'h0, regRdValid_ff, pend, ovr});
        tcd_host_i.access(1'h0, 6'h09, 16'h0000, q, v);
        chk("readout after reset", 16'h0000, q);
        tcd_host_i.access(1'h0, 6'h08, 16'h0000, q, v);
        chk("desc after reset", 16'h0549, q);
        final_report();
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        #20000;
        n_mismatch++;
        final_report();
    end
endmodule // tcd_top_test
bind tcd_top tcd_top_asserts tcd_top_asserts_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regRdStb(regRdStb), .regWrStb(regWrStb),
    .regRdData_ff(regRdData_ff), .regRdValid_ff(regRdValid_ff));
`default_nettype wire
